/* File: design/ee_defines.svh */
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define EE_CLK_MHZ                40
`define EE_WRITE_CYCLE_TIME_MS    5
`define EE_WRITE_CYCLES           (`EE_WRITE_CYCLE_TIME_MS * 1000 * `EE_CLK_MHZ)
`define EE_POWER_UP_WAIT_TIME_US  100
`define EE_POWER_UP_CYCLES        (`EE_POWER_UP_WAIT_TIME_US * `EE_CLK_MHZ)
`define EE_SCL_QUARTER            25

// ----------------------------------------------------------------
// protocol fields
// ----------------------------------------------------------------
`define EE_TYPE_CODE              4'hA
`define EE_DIR_READ               1'b1
`define EE_DIR_WRITE              1'b0
`define EE_LAST_BIT               4'h7
`define EE_ACK_BIT                4'h8
`define EE_CNT_SKIP               4'hF
`define EE_ARRAY_BYTES            2048
`define EE_TMR_W                  18

`endif

/* File: design/ee_pkg.sv */
`include "ee_defines.svh"

package ee_pkg;

  // ----------------------------------------------------------------
  // device end
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE, D_HDR, D_WADDR, D_WDATA, D_RDATA
  } ee_dev_st_t;

  typedef struct packed {
    ee_dev_st_t             st;
    logic [3:0]             cnt;
    logic [7:0]             sh;
    logic [2:0]             hi;
    logic [10:0]            addr;
    logic [15:0][7:0]       pbuf;
    logic [15:0]            mask;
    logic                   pend;
    logic                   busy;
    logic [`EE_TMR_W-1:0]   tmr;
    logic [4:0]             pidx;
    logic [6:0]             prow;
    logic                   mack;
    logic                   oe;
    logic                   scl_q;
    logic                   sda_q;
  } ee_dev_t;

  // ----------------------------------------------------------------
  // host end
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_WRITE, OP_READ_CUR, OP_READ_RAND
  } ee_op_t;

  typedef enum logic [2:0] {
    H_PWR, H_IDLE, H_START, H_TX, H_RX, H_STOP
  } ee_host_st_t;

  typedef enum logic [2:0] {
    G_HDR, G_ADDR, G_DATA, G_RHDR, G_RDATA, G_POLL, G_END
  } ee_stage_t;

  typedef struct packed {
    ee_host_st_t  st;
    ee_stage_t    stage;
    ee_op_t       op;
    logic [1:0]   ph;
    logic [4:0]   qcnt;
    logic [11:0]  pwr;
    logic [3:0]   bitn;
    logic [7:0]   sh;
    logic [4:0]   len;
    logic [10:0]  addr;
    logic         ack;
    logic         scl;
    logic         oe;
    logic [7:0]   rd_data;
    logic         rd_valid;
    logic         wr_take;
    logic         done;
    logic         nack;
  } ee_host_t;

endpackage

/* File: design/ee_if.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-wire link: host clock, shared open-drain data, write protect
// ----------------------------------------------------------------
interface ee_if;
  logic scl;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic wp;
  logic sda;

  // wired-and of both open-drain drivers, pulled high when released
  assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));

  modport host (output scl, output h_sda_o, output h_sda_oe,
                output wp, input sda);
  modport dev  (input scl, input wp, input sda,
                output d_sda_o, output d_sda_oe);
endinterface

/* File: design/ee_device.sv */
`timescale 1ns/1ps
`include "ee_defines.svh"

// Notes on behaviour
// - page write programs one to sixteen bytes
// - data bytes acked every nine clocks
// - stop starts timed programming, then standby
// - column bits increment per data byte
// - over sixteen bytes, column wraps and overwrites
// - no header ack while programming runs
// - header acked again once programming finished
// - read header has direction bit one
// - counter holds last address plus one
// - current read acks, shifts byte, increments
// - host ends current read: nack, stop
// - host ack requests next sequential byte
// - counter wraps past top address to zero
// - random read: dummy write, then current read
// - start after dummy write cancels programming
// - commands ignored until power-on reset releases
// - host waits before first command after power
// - header type code must be 1010
// - receiver acks each byte on ninth clock
// - 128 pages of 16, 11-bit address
// - write protect high blocks all programming
module ee_device
  import ee_pkg::*;
#(
  parameter int PROG_CYCLES = `EE_WRITE_CYCLES,
  parameter int DEPTH       = `EE_ARRAY_BYTES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  ee_if.dev         bus,
  output wire logic busy,
  output wire logic [10:0] counter
);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  ee_dev_t    s;
  ee_dev_t    next_s;
  logic [7:0] mem [0:DEPTH-1];
  logic [7:0] rd_byte;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic [3:0] col;
  logic       hdr_ok;

  // ----------------------------------------------------------------
  // line events, taken against the previous sample
  // ----------------------------------------------------------------
  assign rise  = bus.scl && !s.scl_q;
  assign fall  = !bus.scl && s.scl_q;
  // sda moving while scl stays high marks start and stop
  assign start = bus.scl && s.scl_q && s.sda_q && !bus.sda;
  assign stop  = bus.scl && s.scl_q && !s.sda_q && bus.sda;
  assign col   = s.addr[3:0];
  // header accepted only for our type code and while idle
  assign hdr_ok = (s.sh[7:4] == `EE_TYPE_CODE) && !s.busy;

  // byte at the address counter, for the read path
  assign rd_byte = mem[s.addr];

  // open drain: only ever pulls low
  assign bus.d_sda_o  = 1'b0;
  assign bus.d_sda_oe = s.oe;
  assign busy         = s.busy;
  assign counter      = s.addr;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.scl_q = bus.scl;
    next_s.sda_q = bus.sda;

    // self-timed programming: copy page while the timer runs out
    if (s.busy) begin
      if (!s.pidx[4]) begin
        next_s.pidx = s.pidx + 5'h01;
      end
      if (s.tmr == '0) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.tmr = s.tmr - `EE_TMR_W'(1);
      end
    end

    if (start) begin
      // any start restarts the parser and drops unissued writes
      next_s.st   = D_HDR;
      // the scl fall that closes the start is not a data bit
      next_s.cnt  = `EE_CNT_SKIP;
      next_s.oe   = 1'b0;
      next_s.pend = 1'b0;
    end else if (stop) begin
      next_s.st = D_IDLE;
      next_s.oe = 1'b0;
      if (s.pend && !s.busy) begin
        // launch programming of the loaded partial or full page
        next_s.busy = 1'b1;
        next_s.tmr  = `EE_TMR_W'(PROG_CYCLES - 1);
        next_s.pidx = 5'h00;
        next_s.prow = s.addr[10:4];
        next_s.pend = 1'b0;
      end
    end else if (rise && s.st != D_IDLE) begin
      // sample on the rising clock edge
      if (s.cnt == `EE_ACK_BIT) begin
        next_s.mack = !bus.sda;
      end else if (s.st != D_RDATA) begin
        next_s.sh = {s.sh[6:0], bus.sda};
      end
    end else if (fall && s.st != D_IDLE) begin
      // change outputs on the falling clock edge
      if (s.cnt == `EE_LAST_BIT) begin
        next_s.cnt = `EE_ACK_BIT;
        next_s.oe  = 1'b0;
        case (s.st)
          D_HDR: begin
            if (hdr_ok) begin
              next_s.oe = 1'b1;
              next_s.hi = s.sh[3:1];
              if (s.sh[0] == `EE_DIR_READ) begin
                next_s.st   = D_RDATA;
                next_s.mack = 1'b1;
              end else begin
                next_s.st = D_WADDR;
              end
            end else begin
              next_s.st = D_IDLE;
            end
          end
          D_WADDR: begin
            // dummy write ends here if a start follows
            next_s.oe   = 1'b1;
            next_s.addr = {s.hi, s.sh};
            next_s.mask = 16'h0000;
            next_s.st   = D_WDATA;
          end
          D_WDATA: begin
            next_s.oe = 1'b1;
            if (!bus.wp) begin
              // later bytes on the same column replace earlier ones
              next_s.pbuf[col] = s.sh;
              next_s.mask[col] = 1'b1;
              next_s.pend      = 1'b1;
            end
            next_s.addr[3:0] = col + 4'h1;
          end
          default: begin
            next_s.oe = 1'b0;
          end
        endcase
      end else if (s.cnt == `EE_ACK_BIT) begin
        next_s.cnt = 4'h0;
        next_s.oe  = 1'b0;
        if (s.st == D_RDATA) begin
          if (s.mack) begin
            // shift out the byte at the counter, then step it
            next_s.sh   = rd_byte;
            next_s.oe   = !rd_byte[7];
            next_s.addr = s.addr + 11'h001;
          end else begin
            next_s.st = D_IDLE;
          end
        end
      end else begin
        next_s.cnt = s.cnt + 4'h1;
        if (s.st == D_RDATA) begin
          next_s.sh = {s.sh[6:0], 1'b0};
          next_s.oe = !s.sh[6];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register; reset stands for the power-on reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s       <= '0;
      s.st    <= D_IDLE;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // array write port: one loaded column per cycle after the stop
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (s.busy && !s.pidx[4] && s.mask[s.pidx[3:0]]) begin
      mem[{s.prow, s.pidx[3:0]}] <= s.pbuf[s.pidx[3:0]];
    end
  end

endmodule

/* File: design/ee_host.sv */
`timescale 1ns/1ps
`include "ee_defines.svh"

// ----------------------------------------------------------------
// bus controller: runs commands, bit-bangs scl and sda
// ----------------------------------------------------------------
module ee_host
  import ee_pkg::*;
#(
  parameter int QUARTER  = `EE_SCL_QUARTER,
  parameter int PUP_WAIT = `EE_POWER_UP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  ee_if.host              bus,
  input  wire logic       cmd_valid,
  output wire logic       cmd_ready,
  input  wire ee_op_t     cmd_op,
  input  wire logic [10:0] cmd_addr,
  input  wire logic [4:0] cmd_len,
  input  wire logic [7:0] wr_data,
  output wire logic       wr_take,
  output wire logic [7:0] rd_data,
  output wire logic       rd_valid,
  output wire logic       done,
  output wire logic       nack,
  input  wire logic       wp_in
);

  ee_host_t s;
  ee_host_t next_s;
  logic     tick;
  logic     last;

  // header byte: type code, high address bits, direction
  function automatic logic [7:0] hdr(input logic [2:0] hi,
                                     input logic dir);
    hdr = {`EE_TYPE_CODE, hi, dir};
  endfunction

  assign tick         = s.qcnt == 5'(QUARTER - 1);
  assign last         = tick && s.ph == 2'h3;
  assign cmd_ready    = s.st == H_IDLE;
  assign bus.scl      = s.scl;
  assign bus.h_sda_o  = 1'b0;
  assign bus.h_sda_oe = s.oe;
  assign bus.wp       = wp_in;
  assign wr_take      = s.wr_take;
  assign rd_data      = s.rd_data;
  assign rd_valid     = s.rd_valid;
  assign done         = s.done;
  assign nack         = s.nack;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s          = s;
    next_s.wr_take  = 1'b0;
    next_s.rd_valid = 1'b0;
    next_s.done     = 1'b0;
    if (s.st != H_PWR && s.st != H_IDLE) begin
      next_s.qcnt = tick ? 5'h00 : s.qcnt + 5'h01;
      if (tick) begin
        next_s.ph = s.ph + 2'h1;
      end
    end
    case (s.st)
      H_PWR: begin
        next_s.pwr = s.pwr + 12'h001;
        if (s.pwr == 12'(PUP_WAIT - 1)) begin
          next_s.st = H_IDLE;
        end
      end
      H_IDLE: begin
        if (cmd_valid) begin
          next_s.op    = cmd_op;
          next_s.addr  = cmd_addr;
          next_s.len   = cmd_len;
          next_s.nack  = 1'b0;
          next_s.stage = G_HDR;
          next_s.st    = H_START;
          next_s.ph    = 2'h0;
          next_s.qcnt  = 5'h00;
        end
      end
      H_START: begin
        // release sda high, raise scl, pull sda low, lower scl
        if (tick && s.ph == 2'h0) next_s.scl = 1'b1;
        if (tick && s.ph == 2'h1) next_s.oe = 1'b1;
        if (tick && s.ph == 2'h2) next_s.scl = 1'b0;
        if (s.ph == 2'h0 && !tick) next_s.oe = 1'b0;
        if (last) begin
          next_s.st   = H_TX;
          next_s.bitn = 4'h0;
          if (s.stage == G_RHDR || s.op == OP_READ_CUR) begin
            next_s.sh = hdr(s.addr[10:8], `EE_DIR_READ);
          end else begin
            next_s.sh = hdr(s.addr[10:8], `EE_DIR_WRITE);
          end
        end
      end
      H_TX, H_RX: begin
        if (s.ph == 2'h0) begin
          if (s.bitn == `EE_ACK_BIT) begin
            next_s.oe = s.st == H_RX && s.len != 5'h01;
          end else begin
            next_s.oe = s.st == H_TX && !s.sh[7];
          end
        end
        if (tick && s.ph == 2'h0) next_s.scl = 1'b1;
        if (tick && s.ph == 2'h1) begin
          if (s.bitn == `EE_ACK_BIT) begin
            next_s.ack = !bus.sda;
          end else if (s.st == H_RX) begin
            next_s.sh = {s.sh[6:0], bus.sda};
          end
        end
        if (tick && s.ph == 2'h2) begin
          next_s.scl  = 1'b0;
          next_s.bitn = s.bitn + 4'h1;
          if (s.st == H_TX && s.bitn != `EE_ACK_BIT) begin
            next_s.sh = {s.sh[6:0], 1'b0};
          end
        end
        if (last && s.bitn == 4'h9) begin
          next_s.bitn = 4'h0;
          next_s.oe   = 1'b0;
          if (s.st == H_RX) begin
            next_s.rd_data  = s.sh;
            next_s.rd_valid = 1'b1;
            next_s.len      = s.len - 5'h01;
            if (s.len == 5'h01) begin
              next_s.st    = H_STOP;
              next_s.stage = G_END;
            end
          end else begin
            case (s.stage)
              G_HDR, G_RHDR: begin
                if (!s.ack) begin
                  next_s.nack  = 1'b1;
                  next_s.st    = H_STOP;
                  next_s.stage = G_END;
                end else if (s.op == OP_WRITE || s.stage == G_HDR &&
                             s.op == OP_READ_RAND) begin
                  next_s.stage = G_ADDR;
                  next_s.sh    = s.addr[7:0];
                end else begin
                  next_s.stage = G_RDATA;
                  next_s.st    = H_RX;
                end
              end
              G_ADDR: begin
                if (s.op == OP_WRITE) begin
                  next_s.stage   = G_DATA;
                  next_s.sh      = wr_data;
                  next_s.wr_take = 1'b1;
                end else begin
                  next_s.stage = G_RHDR;
                  next_s.st    = H_START;
                end
              end
              G_DATA: begin
                next_s.len = s.len - 5'h01;
                if (s.len == 5'h01) begin
                  next_s.st    = H_STOP;
                  next_s.stage = G_POLL;
                end else begin
                  next_s.sh      = wr_data;
                  next_s.wr_take = 1'b1;
                end
              end
              default: begin
                // acknowledge polling until the write cycle ends
                next_s.st = H_STOP;
                if (s.ack) next_s.stage = G_END;
              end
            endcase
          end
        end
      end
      default: begin
        // stop: scl low with sda low, raise scl, release sda
        if (s.ph == 2'h0 && !tick) next_s.oe = 1'b1;
        if (tick && s.ph == 2'h0) next_s.scl = 1'b1;
        if (tick && s.ph == 2'h1) next_s.oe = 1'b0;
        if (last) begin
          if (s.stage == G_END) begin
            next_s.st   = H_IDLE;
            next_s.done = 1'b1;
          end else begin
            next_s.st = H_START;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s     <= '0;
      s.st  <= H_PWR;
      s.scl <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* File: testbench/ee_assertions.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// link checker on the shared two-wire signals
// ----------------------------------------------------------------
module ee_assertions #(
  parameter int PROG_CYCLES = 300,
  parameter int PUP_WAIT    = 20
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        scl,
  input wire logic        h_sda_o,
  input wire logic        h_sda_oe,
  input wire logic        d_sda_o,
  input wire logic        d_sda_oe,
  input wire logic        wp,
  input wire logic        sda,
  input wire logic        busy,
  input wire logic [10:0] counter
);
  logic       scl_q;
  logic       sda_q;
  logic       bsy_q;
  logic       wr_ok;
  logic [7:0] bits;
  logic [7:0] sh;
  int         bcnt;
  int         pcnt;
  logic       rise;
  logic       start;

  // clock rise and start seen on the sampled lines
  assign rise  = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;

  // bits since start, header shift, busy and power-up counts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bsy_q <= 1'b0;
      wr_ok <= 1'b0;
      bits  <= 8'h00;
      sh    <= 8'h00;
      bcnt  <= 0;
      pcnt  <= 0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      bcnt  <= busy ? bcnt + 1 : 0;
      pcnt  <= (pcnt < PUP_WAIT) ? pcnt + 1 : pcnt;
      if (start) begin
        bits <= 8'h00;
      end else if (rise) begin
        bits  <= bits + 8'h01;
        sh    <= {sh[6:0], sda};
        bsy_q <= busy;
        wr_ok <= (bits == 8'h08) ? (!sda && !sh[0]) : wr_ok;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_drive_scl_low:
    assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device sda moved with scl high");
  a_busy_silent:
    assert property (busy |-> !d_sda_oe)
    else $error("device drove sda while programming");
  a_hdr_nack_busy:
    assert property (rise && bits == 8'h08 && busy && bsy_q |-> sda)
    else $error("header acked while programming");
  a_hdr_ack_idle:
    assert property (rise && bits == 8'h08 && !busy && !bsy_q
                     && sh[7:4] == 4'hA |-> !sda)
    else $error("header not acked in standby");
  a_data_ack:
    assert property (rise && bits > 8'h10 && bits % 9 == 8 && wr_ok |-> !sda)
    else $error("write byte not acked");
  a_wp_blocks:
    assert property ($rose(busy) |-> !wp)
    else $error("programming began under write protect");
  a_prog_max:
    assert property (busy |-> bcnt < PROG_CYCLES)
    else $error("programming too long");
  a_prog_full:
    assert property ($fell(busy) |-> bcnt >= PROG_CYCLES - 1)
    else $error("programming too short");
  a_reset_quiet:
    assert property ($rose(rst_n) |-> !d_sda_oe && !busy && counter == 11'h000)
    else $error("device not idle after reset");
  a_pup_wait:
    assert property (start |-> pcnt >= PUP_WAIT)
    else $error("command before power-up wait");
endmodule

/* File: testbench/ee_tb_top.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// bench: host and device joined over the two-wire link
// ----------------------------------------------------------------
module ee_tb_top
  import ee_pkg::*;
();
  localparam int PROG = 300;
  localparam int PUPW = 20;

  logic        clk;
  logic        rst_n;
  logic        cmd_valid;
  logic        cmd_ready;
  ee_op_t      cmd_op;
  logic [10:0] cmd_addr;
  logic [4:0]  cmd_len;
  logic [7:0]  wr_data;
  logic        wr_take;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        done;
  logic        nack;
  logic        wp_in;
  logic        busy;
  logic [10:0] counter;
  int          nbusy;
  int          nprog;
  logic [10:0] ecnt;
  logic [7:0]  ref_mem [2048];
  bit          ref_ok  [2048];
  logic [7:0]  wbuf    [32];
  logic [7:0]  rq      [$];
  int          errors;
  int          num_checks;
  int          seed;
  int          ncyc;

  ee_if ee_if_inst ();

  ee_host #(.QUARTER(4), .PUP_WAIT(PUPW)) ee_host_inst (
    .clk(clk), .rst_n(rst_n), .bus(ee_if_inst.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack(nack),
    .wp_in(wp_in));

  ee_device #(.PROG_CYCLES(PROG), .DEPTH(2048)) ee_device_inst (
    .clk(clk), .rst_n(rst_n), .bus(ee_if_inst.dev), .busy(busy),
    .counter(counter));

  ee_assertions #(.PROG_CYCLES(PROG), .PUP_WAIT(PUPW)) ee_assertions_inst (
    .clk(clk), .rst_n(rst_n), .scl(ee_if_inst.scl),
    .h_sda_o(ee_if_inst.h_sda_o), .h_sda_oe(ee_if_inst.h_sda_oe),
    .d_sda_o(ee_if_inst.d_sda_o), .d_sda_oe(ee_if_inst.d_sda_oe),
    .wp(ee_if_inst.wp), .sda(ee_if_inst.sda), .busy(busy),
    .counter(counter));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // counts every cycle of self-timed programming
  always @(posedge clk) begin
    if (busy === 1'b1) nbusy <= nbusy + 1;
  end

  // address of the i-th byte of a page write: the column wraps
  function automatic logic [10:0] page_col(input logic [10:0] a,
                                           input int i);
    page_col = {a[10:4], a[3:0] + 4'(i)};
  endfunction

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic hang(input int n);
    if (n > 50000) begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
    end
  endtask

  task automatic end_test(input string name);
    check(11'(ee_if_inst.scl), 11'h001);
    check(11'(ee_if_inst.sda), 11'h001);
    $display("test %s done: checks %0d errors %0d", name, num_checks, errors);
  endtask

  // one command, feeding write bytes and collecting read bytes
  task automatic run_cmd(input ee_op_t op, input logic [10:0] a,
                         input logic [4:0] len);
    int k;
    int b0;
    k = 0;
    ncyc = 0;
    while (cmd_ready !== 1'b1) begin
      @(negedge clk);
      ncyc++;
      hang(ncyc);
    end
    rq.delete();
    b0 = nbusy;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_len = len;
    wr_data = wbuf[0];
    @(negedge clk);
    cmd_valid = 1'b0;
    ncyc = 0;
    while (done !== 1'b1) begin
      if (wr_take === 1'b1) begin
        k++;
        wr_data = wbuf[k[4:0]];
      end
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      @(negedge clk);
      ncyc++;
      hang(ncyc);
    end
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    nprog = nbusy - b0;
  endtask

  task automatic do_write(input logic [10:0] a, input logic [4:0] len,
                          input logic wp);
    int r;
    foreach (wbuf[i]) begin
      r = $random(seed);
      wbuf[i] = r[7:0];
    end
    wp_in = wp;
    run_cmd(OP_WRITE, a, len);
    wp_in = 1'b0;
    check(11'(nack), 11'h000);
    check(11'(busy), 11'h000);
    check(11'(nprog != 0), 11'(!wp));
    check(11'(nprog), wp ? 11'h000 : 11'(PROG));
    if (!wp) begin
      for (int i = 0; i < len; i++) begin
        ref_mem[page_col(a, i)] = wbuf[i];
        ref_ok[page_col(a, i)] = 1'b1;
      end
    end
  endtask

  task automatic do_read(input ee_op_t op, input logic [10:0] a,
                         input logic [4:0] len);
    logic [10:0] s;
    s = (op == OP_READ_CUR) ? ecnt : a;
    run_cmd(op, a, len);
    check(11'(nack), 11'h000);
    check(11'(nprog), 11'h000);
    check(11'(rq.size()), 11'(len));
    foreach (rq[i]) begin
      if (ref_ok[s + 11'(i)])
        check(11'(rq[i]), 11'(ref_mem[s + 11'(i)]));
    end
    ecnt = s + 11'(len);
    check(counter, ecnt);
  endtask

  // main sequence
  initial begin
    int r;
    logic [10:0] a;
    seed = 44422;
    errors = 0;
    num_checks = 0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_WRITE;
    cmd_addr = 11'h000;
    cmd_len = 5'h01;
    wr_data = 8'h00;
    wp_in = 1'b0;
    ecnt = 11'h000;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (PUPW - 2) @(negedge clk);
    check(11'(cmd_ready), 11'h000);
    check(counter, 11'h000);
    end_test("power up");
    do_write(11'h7F0, 5'h10, 1'b0);
    do_write(11'h000, 5'h10, 1'b0);
    do_read(OP_READ_RAND, 11'h7F8, 5'h0C);
    do_read(OP_READ_CUR, 11'h000, 5'h01);
    end_test("page and wrap read");
    do_write(11'h130, 5'h10, 1'b0);
    do_write(11'h13D, 5'h05, 1'b0);
    do_write(11'h245, 5'h14, 1'b0);
    do_read(OP_READ_RAND, 11'h240, 5'h10);
    do_read(OP_READ_RAND, 11'h130, 5'h10);
    end_test("column roll");
    do_write(11'h130, 5'h10, 1'b1);
    do_read(OP_READ_RAND, 11'h130, 5'h10);
    end_test("write protect");
    rst_n = 1'b0;
    @(negedge clk);
    check(11'(busy), 11'h000);
    check(counter, 11'h000);
    rst_n = 1'b1;
    @(negedge clk);
    check(11'(cmd_ready), 11'h000);
    ecnt = 11'h000;
    do_read(OP_READ_CUR, 11'h000, 5'h03);
    end_test("second reset");
    repeat (4) begin
      r = $random(seed);
      a = r[10:0];
      do_write(a, 5'(r[15:12]) + 5'h01, 1'b0);
      do_read(OP_READ_RAND, {a[10:4], 4'h0}, 5'(r[19:16]) + 5'h01);
      do_read(OP_READ_CUR, a, 5'(r[22:21]) + 5'h01);
    end
    end_test("random traffic");
    final_report();
  end
endmodule
